// [design/apf_scan_ctrl.sv]
// Sequencer for a twelve-channel converter with threshold compare, APB registers.
// Assumes the analog macro holds adcData stable by the end of each wait interval.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// RULE1 - Continuous compare scan converts input 0 up to selected channel, storing each.
// RULE2 - In compare scans only channel 0 is compared; interrupt only when it holds.
// RULE3 - Continuous scan restarts at input 0 until enable is cleared.
// RULE4 - One-shot select converts once, always stores, interrupts on match, stops.
// RULE5 - One-shot scan converts 0 to selected once, compares channel 0, halts.
// RULE6 - Direction zero: upper byte at least threshold; one: strictly below threshold.
// RULE7 - Twelve channels, 0 to 11, each with its own result register.
// RULE8 - Writing channel select never clears the conversion-end flag.
// RULE9 - Software clears the conversion-end flag before resuming a stopped converter.
// RULE10 - Control writes or trigger acknowledge may leave results undefined.
// RULE11 - Software reads results before control writes or next trigger acknowledge.
// RULE12 - Stop mode halts the converter; results after release are invalid.
// RULE13 - Software clears enable before stop mode and sets it after release.
// RULE14 - Idle and subclock keep running; results after idle release are invalid.
// RULE15 - High-speed mode forbids control writes and triggers during stabilization.
// RULE16 - Latency is stabilization plus conversion plus wait plus trigger response.
// RULE17 - Normal mode: control write or trigger during conversion restarts it.
// RULE18 - Collision with stabilization end reinserts 64 clocks of stabilization, repeatedly.
// RULE19 - Trigger and control write intervals are kept above 64 clocks.
// RULE20 - Result store and qualified interrupt pulse happen in the completing cycle.
module apf_scan_ctrl
  import apf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              extTrigger,
  input  wire logic              stopMode,
  input  wire logic              idleMode,
  input  wire logic [RES_W-1:0]  adcData,
  output apf_adc_req_s           adcReq,
  output logic                   conversionEndIrq
);

  apf_state_e       state;
  logic [CNT_W-1:0] cnt;
  logic [CH_W-1:0]  ch;
  logic             converterEnable;
  logic             triggerMode;
  logic [1:0]       opMode;
  logic             highSpeedSelect;
  logic [1:0]       convTimeSel;
  logic [CH_W-1:0]  channelSelect;
  logic             compareEnable;
  logic             compareDirection;
  logic [7:0]       compareThreshold;
  logic             conversionEndFlag;
  logic             resultValid;
  logic             resultStale;
  logic [RES_W-1:0] result [NUM_CH];
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic             trigPrev;
  logic             stopPrev;
  logic             idlePrev;
  logic [31:0]      next_prdata;

  function automatic logic isResult(input logic [ADDR_W-1:0] a);
    return (a >= OFF_RES_BASE) && (a[1:0] == 2'h0)
        && (a[ADDR_W-1:2] - OFF_RES_BASE[ADDR_W-1:2] < 6'(NUM_CH));
  endfunction

  function automatic logic [CH_W-1:0] resIndex(input logic [ADDR_W-1:0] a);
    return CH_W'(a[ADDR_W-1:2] - OFF_RES_BASE[ADDR_W-1:2]);
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_MODE0) || (a == OFF_MODE1) || (a == OFF_MODE2)
        || (a == OFF_CHSEL) || (a == OFF_CMPMODE) || (a == OFF_CMPTHR)
        || (a == OFF_FLAG) || isResult(a);
  endfunction

  // Bus decode; the slave never inserts wait states.
  logic apbSetup;
  logic wrAcc;
  assign apbSetup = psel & ~penable;
  assign wrAcc    = psel & penable & pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~isMapped(paddr);

  logic restartWrite;
  logic ctrlWrite;
  logic flagClear;
  assign restartWrite = wrAcc & ((paddr == OFF_MODE0) | (paddr == OFF_MODE2)
                      | (paddr == OFF_CHSEL) | (paddr == OFF_CMPMODE)
                      | (paddr == OFF_CMPTHR));
  assign ctrlWrite = restartWrite | (wrAcc & (paddr == OFF_MODE1));
  assign flagClear = wrAcc & (paddr == OFF_FLAG) & pwdata[FLAG_IRQ_BIT];

  // Pins are asynchronous; adcData is assumed static while it is sampled.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {extTrigger, stopMode, idleMode, adcData};
      sync2 <= sync1;
    end
  end

  logic             trigSync;
  logic             stopSync;
  logic             idleSync;
  logic [RES_W-1:0] dataSync;
  assign trigSync = sync2[SYNC_W-1];
  assign stopSync = sync2[SYNC_W-2];
  assign idleSync = sync2[SYNC_W-3];
  assign dataSync = sync2[RES_W-1:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      trigPrev <= 1'b0;
      stopPrev <= 1'b0;
      idlePrev <= 1'b0;
    end else begin
      trigPrev <= trigSync;
      stopPrev <= stopSync;
      idlePrev <= idleSync;
    end
  end

  logic trigEvent;
  assign trigEvent = converterEnable & triggerMode & trigSync & ~trigPrev
                   & (state != ST_OFF) & (state != ST_HALT);

  always_ff @(posedge clk) begin
    if (rst) begin
      converterEnable <= 1'b0;
      triggerMode     <= 1'b0;
      opMode          <= MD_RST;
    end else if (wrAcc && paddr == OFF_MODE0) begin
      converterEnable <= pwdata[MODE0_CE_BIT];
      triggerMode     <= pwdata[MODE0_TMD_BIT];
      opMode          <= pwdata[MODE0_MD_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      highSpeedSelect <= 1'b0;
      convTimeSel     <= CT_RST;
    end else if (wrAcc && paddr == OFF_MODE1) begin
      highSpeedSelect <= pwdata[MODE1_HS_BIT];
    end else if (wrAcc && paddr == OFF_MODE2) begin
      convTimeSel <= pwdata[MODE2_CT_LSB +: 2];
    end
  end

  // Out-of-range selections are clamped to the last channel. [RULE7]
  always_ff @(posedge clk) begin
    if (rst) begin
      channelSelect <= CHSEL_RST;
    end else if (wrAcc && paddr == OFF_CHSEL) begin
      channelSelect <= (pwdata[CH_W-1:0] > CH_LAST) ? CH_LAST : pwdata[CH_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      compareEnable    <= 1'b0;
      compareDirection <= 1'b0;
      compareThreshold <= THR_RST;
    end else if (wrAcc && paddr == OFF_CMPMODE) begin
      compareEnable    <= pwdata[CMP_EN_BIT];
      compareDirection <= pwdata[CMP_DIR_BIT];
    end else if (wrAcc && paddr == OFF_CMPTHR) begin
      compareThreshold <= pwdata[7:0];
    end
  end

  logic             scanMode;
  logic             oneShot;
  logic [CH_W-1:0]  firstCh;
  logic             lastCh;
  logic [CNT_W-1:0] convLoad;
  logic             collide;
  assign scanMode = (opMode == MD_CONT_SCAN) | (opMode == MD_ONE_SCAN); // [RULE1]
  assign oneShot  = (opMode == MD_ONE_SEL) | (opMode == MD_ONE_SCAN);
  assign firstCh  = scanMode ? '0 : channelSelect;
  assign lastCh   = ~scanMode | (ch == channelSelect);
  assign convLoad = ({7'h00, convTimeSel} + 9'd1) * CONV_UNIT_CLOCKS - 9'd1;
  assign collide  = restartWrite | trigEvent;

  logic done;
  assign done = converterEnable & ~stopSync & (state == ST_WAIT)
              & (cnt == '0) & ~collide;

  // Stabilization runs before the trigger wait; after the trigger sync come conversion and wait. [RULE16]
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_OFF;
      cnt   <= '0;
      ch    <= '0;
    end else if (!converterEnable) begin
      state <= ST_OFF;
      cnt   <= '0;
    end else if (stopSync) begin
      state <= state; // [RULE12]
    end else begin
      case (state)
        ST_OFF: begin
          state <= ST_STAB;
          cnt   <= STAB_CLOCKS - 9'd1;
        end
        ST_STAB: begin
          if (cnt != '0) begin
            cnt <= cnt - 9'd1;
          end else if (collide) begin
            cnt <= STAB_CLOCKS - 9'd1; // [RULE18]
          end else if (triggerMode) begin
            state <= ST_TRIG;
          end else begin
            state <= ST_CONV;
            ch    <= firstCh;
            cnt   <= convLoad;
          end
        end
        ST_TRIG: begin
          if (trigEvent) begin
            state <= ST_CONV;
            ch    <= firstCh;
            cnt   <= convLoad;
          end
        end
        ST_CONV, ST_WAIT: begin
          if (collide) begin
            state <= ST_STAB; // [RULE17]
            cnt   <= STAB_CLOCKS - 9'd1;
          end else if (cnt != '0) begin
            cnt <= cnt - 9'd1;
          end else if (state == ST_CONV) begin
            state <= ST_WAIT;
            cnt   <= WAIT_CLOCKS - 9'd1;
          end else if (!lastCh) begin
            state <= ST_CONV;
            ch    <= ch + 4'h1; // [RULE1]
            cnt   <= convLoad;
          end else if (oneShot) begin
            state <= ST_HALT; // [RULE4] [RULE5]
          end else if (triggerMode) begin
            state <= ST_TRIG;
          end else begin
            state <= ST_CONV; // [RULE3]
            ch    <= firstCh;
            cnt   <= convLoad;
          end
        end
        ST_HALT: begin
          if (restartWrite) begin
            state <= ST_STAB;
            cnt   <= STAB_CLOCKS - 9'd1;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  assign adcReq.sample  = (state == ST_CONV);
  assign adcReq.channel = ch;

  // Every completed conversion is stored, matched or not. [RULE1] [RULE4] [RULE7]
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        result[i] <= '0;
      end
    end else if (done) begin
      result[ch] <= dataSync; // [RULE20]
    end
  end

  // Scans compare only input 0; select modes compare the selected input.
  logic [7:0] upperByte;
  logic       cmpHit;
  logic       qualify;
  assign upperByte = dataSync[RES_W-1:RES_W-8];
  assign cmpHit    = compareDirection ? (upperByte < compareThreshold)
                                      : (upperByte >= compareThreshold); // [RULE6]
  assign qualify   = compareEnable ? (cmpHit & (~scanMode | (ch == '0)))
                                   : lastCh; // [RULE2] [RULE5]

  always_ff @(posedge clk) begin
    if (rst) begin
      conversionEndIrq <= 1'b0;
    end else begin
      conversionEndIrq <= done & qualify; // [RULE20]
    end
  end

  // A completion in the clearing cycle wins; channel writes never touch it. [RULE8]
  always_ff @(posedge clk) begin
    if (rst) begin
      conversionEndFlag <= 1'b0;
    end else if (done && qualify) begin
      conversionEndFlag <= 1'b1;
    end else if (flagClear) begin
      conversionEndFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resultValid <= 1'b0;
    end else if (done) begin
      resultValid <= 1'b1;
    end else if (ctrlWrite || trigEvent) begin
      resultValid <= 1'b0; // [RULE10]
    end
  end

  // Idle keeps converting, but the held input is lost; only a disable clears this.
  always_ff @(posedge clk) begin
    if (rst) begin
      resultStale <= 1'b0;
    end else if ((stopPrev && !stopSync) || (idlePrev && !idleSync)) begin
      resultStale <= 1'b1; // [RULE12] [RULE14]
    end else if (!converterEnable) begin
      resultStale <= 1'b0;
    end
  end

  logic busy;
  assign busy = (state == ST_STAB) | (state == ST_CONV) | (state == ST_WAIT);

  always_comb begin
    next_prdata = '0;
    if (paddr == OFF_MODE0) begin
      next_prdata[MODE0_CE_BIT]      = converterEnable;
      next_prdata[MODE0_BUSY_BIT]    = busy;
      next_prdata[MODE0_TMD_BIT]     = triggerMode;
      next_prdata[MODE0_MD_LSB +: 2] = opMode;
    end else if (paddr == OFF_MODE1) begin
      next_prdata[MODE1_HS_BIT] = highSpeedSelect;
    end else if (paddr == OFF_MODE2) begin
      next_prdata[MODE2_CT_LSB +: 2] = convTimeSel;
    end else if (paddr == OFF_CHSEL) begin
      next_prdata[CH_W-1:0] = channelSelect;
    end else if (paddr == OFF_CMPMODE) begin
      next_prdata[CMP_EN_BIT]  = compareEnable;
      next_prdata[CMP_DIR_BIT] = compareDirection;
    end else if (paddr == OFF_CMPTHR) begin
      next_prdata[7:0] = compareThreshold;
    end else if (paddr == OFF_FLAG) begin
      next_prdata[FLAG_IRQ_BIT]   = conversionEndFlag;
      next_prdata[FLAG_VALID_BIT] = resultValid;
      next_prdata[FLAG_STALE_BIT] = resultStale;
    end else if (isResult(paddr)) begin
      next_prdata[RES_W-1:0] = result[resIndex(paddr)];
    end
  end

  // Read data is captured in the setup phase so the access phase needs no wait.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (apbSetup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule // apf_scan_ctrl
`default_nettype wire

// [pkg/apf_pkg.sv]
// Constants, register map and carrier types for the compare-mode scan controller.
// Assumes a single 125 MHz clock and an APB master with 32-bit data.
`default_nettype none
package apf_pkg;

  localparam int NUM_CH = 12;
  localparam int CH_W   = 4;
  localparam int RES_W  = 10;
  localparam int ADDR_W = 8;
  localparam int CNT_W  = 9;
  localparam int SYNC_W = 13;

  localparam logic [ADDR_W-1:0] OFF_MODE0    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE1    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MODE2    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CHSEL    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CMPMODE  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CMPTHR   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_FLAG     = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_RES_BASE = 8'h40;

  localparam int MODE0_MD_LSB   = 0;
  localparam int MODE0_TMD_BIT  = 3;
  localparam int MODE0_BUSY_BIT = 6;
  localparam int MODE0_CE_BIT   = 7;
  localparam int MODE1_HS_BIT   = 0;
  localparam int MODE2_CT_LSB   = 0;
  localparam int CMP_DIR_BIT    = 6;
  localparam int CMP_EN_BIT     = 7;
  localparam int FLAG_IRQ_BIT   = 0;
  localparam int FLAG_VALID_BIT = 1;
  localparam int FLAG_STALE_BIT = 2;

  localparam logic [1:0] MD_CONT_SEL  = 2'h0;
  localparam logic [1:0] MD_CONT_SCAN = 2'h1;
  localparam logic [1:0] MD_ONE_SEL   = 2'h2;
  localparam logic [1:0] MD_ONE_SCAN  = 2'h3;

  localparam logic [1:0]      MD_RST    = 2'h0;
  localparam logic [1:0]      CT_RST    = 2'h0;
  localparam logic [CH_W-1:0] CHSEL_RST = 4'h0;
  localparam logic [7:0]      THR_RST   = 8'h00;
  localparam logic [CH_W-1:0] CH_LAST   = 4'hb;

  // Stabilization, conversion unit, wait and trigger response, in clocks.
  localparam logic [CNT_W-1:0] STAB_CLOCKS      = 9'd64;
  localparam logic [CNT_W-1:0] CONV_UNIT_CLOCKS = 9'd16;
  localparam logic [CNT_W-1:0] WAIT_CLOCKS      = 9'd8;
  localparam int               TRIG_RESP_CLOCKS = 3;

  typedef enum logic [2:0] {ST_OFF, ST_STAB, ST_TRIG, ST_CONV, ST_WAIT, ST_HALT} apf_state_e;

  typedef struct packed {
    logic            sample;
    logic [CH_W-1:0] channel;
  } apf_adc_req_s;

endpackage
`default_nettype wire

// [dv/apf_scan_monitor.sv]
// Port-level checker for the compare-mode scan controller.
// Assumes it is bound to apf_scan_ctrl and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module apf_scan_monitor
  import apf_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire apf_adc_req_s      adcReq,
  input wire logic              conversionEndIrq
);
  logic       ctlWr;
  logic [7:0] quiet;
  logic [7:0] lowCnt;
  logic [7:0] highCnt;
  assign ctlWr = psel && penable && pwrite &&
                 paddr inside {OFF_MODE0, OFF_MODE2, OFF_CHSEL, OFF_CMPMODE, OFF_CMPTHR};
  // Counters saturate so a long idle stretch never wraps into a false short gap.
  always_ff @(posedge clk) begin
    if (rst || ctlWr) quiet <= 8'h00;
    else if (quiet != 8'hff) quiet <= quiet + 8'h01;
  end
  always_ff @(posedge clk) begin
    lowCnt  <= (rst || adcReq.sample) ? 8'h00 : lowCnt + {7'h00, lowCnt != 8'hff};
    highCnt <= (rst || !adcReq.sample) ? 8'h00 : highCnt + {7'h00, highCnt != 8'hff};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_irq_single: assert property (conversionEndIrq |=> !conversionEndIrq)
    else $error("interrupt pulse longer than one cycle");
  chk_irq_after_wait: assert property (conversionEndIrq |-> lowCnt inside {[7:9]})
    else $error("interrupt not at the end of the wait interval");
  chk_ch_stable: assert property (adcReq.sample && $past(adcReq.sample) |-> $stable(adcReq.channel))
    else $error("channel changed during a conversion");
  chk_ch_range: assert property (adcReq.sample |-> adcReq.channel <= CH_LAST)
    else $error("channel index out of range");
  chk_stab_gap: assert property ($rose(adcReq.sample) |-> quiet >= 8'd64)
    else $error("conversion started inside the stabilization time");
  chk_wait_len: assert property ($fell(adcReq.sample) |-> !adcReq.sample [*8])
    else $error("wait interval shorter than eight clocks");
  chk_conv_len: assert property ($fell(adcReq.sample) |-> highCnt >= 8'd16 || $past(ctlWr))
    else $error("conversion shorter than sixteen clocks");
  chk_write_restart: assert property (ctlWr && adcReq.sample |=> !adcReq.sample [*8])
    else $error("control write did not restart the conversion");
  cover property (conversionEndIrq);
  cover property (ctlWr && adcReq.sample);
  cover property (adcReq.sample && adcReq.channel == CH_LAST);
endmodule // apf_scan_monitor
bind apf_scan_ctrl apf_scan_monitor u_mon (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .adcReq(adcReq), .conversionEndIrq(conversionEndIrq)
);
`default_nettype wire

// [dv/apf_analog_src.sv]
// Analog front-end model: one value per channel, held through the wait interval.
// Assumes the bench sets the channel values between conversions.
`timescale 1ns/10ps
`default_nettype none
module apf_analog_src
  import apf_pkg::*;
(
  input  wire logic             clk,
  input  wire apf_adc_req_s     adcReq,
  input  wire logic [RES_W-1:0] vals [NUM_CH],
  output logic      [RES_W-1:0] adcData
);
  logic [RES_W-1:0] held    = '0;
  logic [3:0]       holdCnt = 4'hf;
  logic             tgl     = 1'b0;
  always_ff @(posedge clk) begin
    tgl <= ~tgl;
    if (adcReq.sample) begin
      held    <= vals[adcReq.channel];
      holdCnt <= 4'h0;
    end else if (holdCnt != 4'hf) begin
      holdCnt <= holdCnt + 4'h1;
    end
  end
  // Past the hold window the value toggles, so late sampling shows up as a wrong result.
  assign adcData = (adcReq.sample || holdCnt < 4'h9) ? held : ~held ^ {RES_W{tgl}};
endmodule // apf_analog_src
`default_nettype wire

// [dv/adc_powerfail_scan_control_test.sv]
// Self-checking bench for the compare-mode scan controller.
// Assumes the package, the analog model and the checker bind are compiled first.
`timescale 1ns/10ps
`default_nettype none
module adc_powerfail_scan_control_test
  import apf_pkg::*;
;
  logic             clk, rst, psel, penable, pwrite, extTrigger, stopMode, idleMode;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]      pwdata, prdata, rdat;
  logic             pready, pslverr, errSeen, conversionEndIrq;
  logic [RES_W-1:0] adcData;
  logic [RES_W-1:0] vals [NUM_CH];
  apf_adc_req_s     adcReq;
  int               nErrors, checkCount, irqCnt, base, up, n;
  int               expQ[$];

  apf_scan_ctrl u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extTrigger(extTrigger), .stopMode(stopMode), .idleMode(idleMode),
    .adcData(adcData), .adcReq(adcReq), .conversionEndIrq(conversionEndIrq));
  apf_analog_src u_src (.clk(clk), .adcReq(adcReq), .vals(vals), .adcData(adcData));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (conversionEndIrq === 1'b1) irqCnt <= irqCnt + 1;

  task automatic report_and_stop;
    if (nErrors == 0 && checkCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      nErrors++;
      report_and_stop();
    end
    @(posedge clk);
  endtask
  function automatic logic expIrq(input logic [7:0] cmp, input int v, input int thr);
    if (!cmp[CMP_EN_BIT]) return 1'b1;
    return cmp[CMP_DIR_BIT] ? ((v >> 2) < thr) : ((v >> 2) >= thr);
  endfunction
  // Software side clears the flag before each restart; each run reads its results before the next write.
  task automatic setup(input logic [7:0] m0, input int sel, input logic [7:0] cmp, input int thr);
    apb(1'b1, OFF_MODE0, 32'h0);
    apb(1'b1, OFF_FLAG, 32'h1);
    apb(1'b1, OFF_CHSEL, 32'(sel));
    apb(1'b1, OFF_CMPMODE, {24'h0, cmp});
    apb(1'b1, OFF_CMPTHR, 32'(thr));
    base = irqCnt;
    apb(1'b1, OFF_MODE0, {24'h0, m0});
  endtask
  task automatic run(input logic [7:0] m0, input int sel, input logic [7:0] cmp, input int thr);
    int lo;
    setup(m0, sel, cmp, thr);
    repeat (400) @(posedge clk);
    lo = m0[0] ? 0 : sel;
    chk("irq count", 32'(irqCnt - base), expIrq(cmp, vals[lo], thr));
    apb(1'b0, OFF_FLAG, 32'h0);
    chk("flag", rdat[FLAG_IRQ_BIT], expIrq(cmp, vals[lo], thr));
    chk("valid", rdat[FLAG_VALID_BIT], 32'h1);
    for (int c = lo; c <= sel; c++) begin
      expQ.push_back(int'(vals[c]));
    end
    for (int c = lo; c <= sel; c++) begin
      apb(1'b0, OFF_RES_BASE + 8'(4 * c), 32'h0);
      chk("result", rdat, 32'(expQ.pop_front()));
    end
  endtask

  initial begin
    {rst, psel, penable, pwrite, extTrigger, stopMode, idleMode} = 7'h40;
    paddr = '0;
    pwdata = '0;
    {nErrors, checkCount, irqCnt} = '0;
    void'($urandom(32'hafad5b56));
    foreach (vals[i]) vals[i] = 10'($urandom_range(0, 1023));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int a = 0; a <= 112; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset read", rdat, 32'h0);
      chk("slave error", errSeen, (a >= 28 && a < 64) || a == 112);
    end
    apb(1'b1, OFF_CHSEL, 32'hf);
    apb(1'b0, OFF_CHSEL, 32'h0);
    chk("channel clamp", rdat, 32'hb);
    for (int k = 0; k < 4; k++) begin
      foreach (vals[i]) vals[i] = 10'($urandom_range(0, 1023));
      up = $urandom_range(1, 254);
      vals[0] = {8'(up), 2'(k)};
      run(8'h83, $urandom_range(1, 11), k[1] ? 8'hc0 : 8'h80, up + (k[0] ^ k[1]));
    end
    run(8'h82, 11, 8'hc0, $urandom_range(0, 255));
    apb(1'b1, OFF_MODE2, 32'h1);
    run(8'h82, 5, 8'h00, 0);
    apb(1'b1, OFF_MODE2, 32'h0);
    vals[0] = 10'h3ff;
    setup(8'h81, 2, 8'h80, 16);
    repeat (400) @(posedge clk);
    chk("scan repeats", irqCnt - base >= 4, 32'h1);
    n = 0;
    while (adcReq.sample !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      nErrors++;
      report_and_stop();
    end
    apb(1'b1, OFF_CHSEL, 32'h1);
    apb(1'b0, OFF_FLAG, 32'h0);
    chk("flag kept", rdat[FLAG_IRQ_BIT], 32'h1);
    chk("valid cleared", rdat[FLAG_VALID_BIT], 32'h0);
    idleMode <= 1'b1;
    repeat (30) @(posedge clk);
    idleMode <= 1'b0;
    base = irqCnt;
    repeat (300) @(posedge clk);
    chk("idle keeps running", irqCnt > base, 32'h1);
    apb(1'b0, OFF_FLAG, 32'h0);
    chk("stale after idle", rdat[FLAG_STALE_BIT], 32'h1);
    apb(1'b1, OFF_MODE0, 32'h0);
    base = irqCnt;
    stopMode <= 1'b1;
    repeat (100) @(posedge clk);
    stopMode <= 1'b0;
    repeat (5) @(posedge clk);
    chk("stopped", 32'(irqCnt - base), 32'h0);
    setup(8'h81, 2, 8'h80, 16);
    repeat (300) @(posedge clk);
    chk("resumes", irqCnt > base, 32'h1);
    setup(8'h8a, 5, 8'h00, 0);
    repeat (100) @(posedge clk);
    chk("waits trigger", 32'(irqCnt - base), 32'h0);
    extTrigger <= 1'b1;
    repeat (3) @(posedge clk);
    extTrigger <= 1'b0;
    repeat (20) @(posedge clk);
    chk("latency", 32'(irqCnt - base), 32'h0);
    repeat (15) @(posedge clk);
    chk("triggered", 32'(irqCnt - base), 32'h1);
    apb(1'b0, OFF_RES_BASE + 8'h14, 32'h0);
    chk("trigger result", rdat, vals[5]);
    report_and_stop();
  end
endmodule // adc_powerfail_scan_control_test
`default_nettype wire
